// File: hw/liu_top.sv
`timescale 1ns/1ps
module liu_top
#(
   parameter int unsigned ID_W  = 32,
   parameter int unsigned CL_W  = 16,
   parameter int unsigned LG_W  = 16,
   parameter int unsigned NCORE = 4,
   parameter int unsigned IDX_W = 2
)
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    ce,
   // memory-page register access
   input  wire liu_pkg::liu_mreq_s      mreq,
   output liu_pkg::liu_rsp_s            mrsp,
   // model-specific register access
   input  wire liu_pkg::liu_xreq_s      xreq,
   output liu_pkg::liu_rsp_s            xrsp,
   // destination matching
   input  wire logic                    dst_valid,
   input  wire logic                    dst_logical,
   input  wire logic [31:0]             dst_id,
   output logic                         dst_hit_valid,
   output logic                         dst_hit,
   // identity and mode
   output logic                         ext_mode,
   output logic [31:0]                  phys_id_out,
   output logic [31:0]                  log_id_out,
   output logic [7:0]                   prio_out,
   // power-aware routing
   input  wire liu_pkg::liu_irq_s       irq,
   input  wire liu_pkg::liu_cstate_e [NCORE-1:0] core_state,
   input  wire logic [NCORE-1:0]        core_busy,
   output logic                         route_valid,
   output logic [IDX_W-1:0]             route_core,
   output logic [7:0]                   route_vec
);
   import liu_pkg::*;

   liu_mode_e         mode_reg;
   liu_mode_e         mode_next;
   logic [ID_W-1:0]   id_reg;
   logic [ID_W-1:0]   id_next;
   logic [CL_W-1:0]   cl_reg;
   logic [CL_W-1:0]   cl_next;
   logic [LG_W-1:0]   lg_reg;
   logic [LG_W-1:0]   lg_next;
   logic [7:0]        tpr_reg;
   logic [7:0]        tpr_next;
   liu_rsp_s          mrsp_reg;
   liu_rsp_s          mrsp_next;
   liu_rsp_s          xrsp_reg;
   liu_rsp_s          xrsp_next;
   logic              hitv_reg;
   logic              hit_reg;
   logic              rtv_reg;
   logic [IDX_W-1:0]  rtc_reg;
   logic [7:0]        rtvec_reg;
   liu_cstate_e       rtst_reg;

   // lowest-numbered set bit of a core mask
   function automatic logic [IDX_W-1:0] first_idx(input logic [NCORE-1:0] m);
      logic [IDX_W-1:0] r;
      r = '0;
      for (int i = NCORE - 1; i >= 0; i--)
      begin
         if (m[i])
         begin
            r = IDX_W'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [NCORE-1:0] state_mask(
      input liu_cstate_e [NCORE-1:0] s,
      input liu_cstate_e             want
   );
      logic [NCORE-1:0] r;
      r = '0;
      for (int i = 0; i < NCORE; i++)
      begin
         r[i] = (s[i] == want);
      end
      return r;
   endfunction

   // mode decode
   wire is_ext    = (mode_reg == LIU_EXT);
   wire is_compat = (mode_reg == LIU_COMPAT);

   // memory-page decode
   wire m_id    = (mreq.addr == OFS_ID);
   wire m_tpr   = (mreq.addr == OFS_TPR);
   wire m_ldr   = (mreq.addr == OFS_LDR);
   wire m_hit   = m_id | m_tpr | m_ldr;
   wire m_take  = mreq.valid & is_compat & m_hit;
   wire m_wr    = m_take & mreq.write;
   wire m_rd    = m_take & ~mreq.write;

   // model-specific register decode
   wire x_mode  = (xreq.index == MSR_MODE);
   wire x_id    = (xreq.index == MSR_ID);
   wire x_tpr   = (xreq.index == MSR_TPR);
   wire x_ldr   = (xreq.index == MSR_LDR);
   wire x_regs  = is_ext & (x_id | x_tpr | x_ldr);
   wire x_take  = xreq.valid & (x_mode | x_regs);
   wire x_wr    = x_take & xreq.write;
   wire x_rd    = x_take & ~xreq.write;

   // identity views, narrow storage zero-extended
   wire [31:0] id_compat = 32'(id_reg[COMPAT_ID_W-1:0]);
   wire [31:0] id_ext    = 32'(id_reg);
   wire [15:0] cl_ext    = 16'(cl_reg);
   wire [15:0] lg_ext    = 16'(lg_reg);
   wire [31:0] ldr_ext   = {cl_ext, lg_ext};
   wire [31:0] ldr_cmp   = {lg_reg[7:0], 24'h000000};
   wire [31:0] mode_word = is_ext ? MODE_EXT_MSK : 32'h00000000;

   // read data, compat id and logical fields sit in the top byte, priority in the low byte
   wire [31:0] m_rdata =
      m_id  ? {id_reg[COMPAT_ID_W-1:0], 24'h000000} :
      m_tpr ? 32'(tpr_reg) :
      m_ldr ? ldr_cmp : 32'h00000000;
   wire [31:0] x_rdata =
      x_mode ? mode_word :
      x_id   ? id_ext :
      x_tpr  ? 32'(tpr_reg) :
      x_ldr  ? ldr_ext : 32'h00000000;

   // register updates
   wire ext_sel = (xreq.wdata & MODE_EXT_MSK) != 32'h00000000;
   assign mode_next = (x_wr & x_mode) ? (ext_sel ? LIU_EXT : LIU_COMPAT)
                                      : mode_reg;
   assign id_next =
      (m_wr & m_id) ? ID_W'(mreq.wdata[COMPAT_LSB +: COMPAT_ID_W]) :
      (x_wr & x_id) ? xreq.wdata[ID_W-1:0] : id_reg;
   // priority is one field shared by both access paths
   assign tpr_next =
      (m_wr & m_tpr) ? mreq.wdata[7:0] :
      (x_wr & x_tpr) ? xreq.wdata[7:0] : tpr_reg;
   assign cl_next =
      (m_wr & m_ldr) ? CL_W'(0) :
      (x_wr & x_ldr) ? xreq.wdata[SUB_W +: CL_W] : cl_reg;
   assign lg_next =
      (m_wr & m_ldr) ? LG_W'(mreq.wdata[COMPAT_LSB +: 8]) :
      (x_wr & x_ldr) ? xreq.wdata[LG_W-1:0] : lg_reg;

   // answers: ack on a served access, drop otherwise
   assign mrsp_next = '{ack:   m_take,
                        drop:  mreq.valid & ~m_take,
                        rdata: m_rd ? m_rdata : 32'h00000000};
   assign xrsp_next = '{ack:   x_take,
                        drop:  xreq.valid & ~x_take,
                        rdata: x_rd ? x_rdata : 32'h00000000};

   // destination match
   wire phys_cmp = ({24'h000000, dst_id[7:0]} == id_compat);
   wire phys_ext = (dst_id == id_ext);
   wire log_cmp  = (dst_id[7:0] & lg_reg[7:0]) != 8'h00;
   wire log_ext  = (dst_id[31:16] == cl_ext) &&
                   ((dst_id[15:0] & lg_ext) != 16'h0000);
   wire hit_now  = dst_logical ? (is_ext ? log_ext : log_cmp)
                               : (is_ext ? phys_ext : phys_cmp);

   // power-aware routing choice
   wire [NCORE-1:0] act_m  = state_mask(core_state, LIU_ACTIVE);
   wire [NCORE-1:0] lit_m  = state_mask(core_state, LIU_LIGHT);
   wire [NCORE-1:0] deep_m = state_mask(core_state, LIU_DEEP);
   wire [NCORE-1:0] free_m = act_m & ~core_busy;
   wire [NCORE-1:0] nrg_m  = (|act_m) ? act_m :
                             (|lit_m) ? lit_m : deep_m;
   wire [NCORE-1:0] prf_m  = (|lit_m)  ? lit_m :
                             (|free_m) ? free_m :
                             (|act_m)  ? act_m : deep_m;
   wire [NCORE-1:0] pick_m = (irq.policy == LIU_PERF) ? prf_m : nrg_m;
   wire [IDX_W-1:0] pick   = first_idx(pick_m);
   wire             any_m  = |pick_m;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_reg <= LIU_COMPAT;
         id_reg   <= RST_ID[ID_W-1:0];
         cl_reg   <= RST_SUB[CL_W-1:0];
         lg_reg   <= RST_SUB[LG_W-1:0];
         tpr_reg  <= RST_TPR;
         mrsp_reg <= '0;
         xrsp_reg <= '0;
      end
      else if (ce)
      begin
         mode_reg <= mode_next;
         id_reg   <= id_next;
         cl_reg   <= cl_next;
         lg_reg   <= lg_next;
         tpr_reg  <= tpr_next;
         mrsp_reg <= mrsp_next;
         xrsp_reg <= xrsp_next;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hitv_reg  <= 1'b0;
         hit_reg   <= 1'b0;
         rtv_reg   <= 1'b0;
         rtc_reg   <= '0;
         rtvec_reg <= 8'h00;
         rtst_reg  <= LIU_ACTIVE;
      end
      else if (ce)
      begin
         hitv_reg  <= dst_valid;
         hit_reg   <= dst_valid & hit_now;
         rtv_reg   <= irq.valid & any_m;
         if (irq.valid & any_m)
         begin
            rtc_reg   <= pick;
            rtvec_reg <= irq.vec;
            rtst_reg  <= core_state[pick];
         end
      end
   end

   assign mrsp          = mrsp_reg;
   assign xrsp          = xrsp_reg;
   assign ext_mode      = is_ext;
   assign phys_id_out   = is_ext ? id_ext : id_compat;
   assign log_id_out    = is_ext ? ldr_ext : 32'(lg_reg[7:0]);
   assign prio_out      = tpr_reg;
   assign dst_hit_valid = hitv_reg;
   assign dst_hit       = hit_reg;
   assign route_valid   = rtv_reg;
   assign route_core    = rtc_reg;
   assign route_vec     = rtvec_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_go_ext;
      ce && xreq.valid && xreq.write && x_mode && ext_sel;
   endsequence

   sequence s_page_req;
      ce && mreq.valid && m_hit;
   endsequence

   sequence s_go_compat;
      ce && xreq.valid && xreq.write && x_mode && !ext_sel;
   endsequence

   sequence s_ext_ldr_wr;
      ce && xreq.valid && xreq.write && x_ldr && is_ext;
   endsequence

   a_page_served: assert property (s_page_req and is_compat |=> mrsp.ack)
      else $error("compat page access not acknowledged");
   a_page_silent: assert property (s_page_req and is_ext |=> !mrsp.ack && mrsp.drop)
      else $error("page access answered in extended mode");
   a_msr_served: assert property (ce && xreq.valid && is_ext && (x_id || x_tpr)
      |=> xrsp.ack)
      else $error("extended register access not acknowledged");
   a_msr_locked: assert property (ce && xreq.valid && is_compat && !x_mode
      |=> xrsp.drop && !xrsp.ack)
      else $error("extended register served in compat mode");
   a_mode_switch: assert property (s_go_ext |=> ext_mode ##0 xrsp.ack)
      else $error("mode enable write did not select extended mode");
   a_id_narrow: assert property (!ext_mode |-> phys_id_out[31:8] == 24'h000000)
      else $error("compat physical id wider than 8 bits");
   a_ldr_split: assert property (s_ext_ldr_wr |=>
      log_id_out[31:16] == 16'($past(xreq.wdata[SUB_W +: CL_W]))
      && log_id_out[15:0] == 16'($past(xreq.wdata[LG_W-1:0])))
      else $error("logical id split wrong");
   a_tpr_path: assert property (ce && xreq.valid && xreq.write && x_tpr && is_ext
      |=> prio_out == $past(xreq.wdata[7:0]))
      else $error("priority write lost");
   a_energy_pick: assert property (ce && irq.valid && irq.policy == LIU_ENERGY
      && (|act_m) |=> route_valid && rtst_reg == LIU_ACTIVE)
      else $error("energy policy woke an idle core");
   a_perf_pick: assert property (ce && irq.valid && irq.policy == LIU_PERF
      && (|lit_m) |=> route_valid && rtst_reg == LIU_LIGHT)
      else $error("performance policy skipped light idle core");
   a_mode_back: assert property (s_go_compat |=> !ext_mode ##0 xrsp.ack)
      else $error("mode enable clear did not return to compat mode");
   a_rsp_excl: assert property (!(mrsp.ack && mrsp.drop) && !(xrsp.ack && xrsp.drop))
      else $error("access both acknowledged and dropped");
   a_rsp_idle: assert property (ce && !mreq.valid && !xreq.valid
      |=> mrsp == '0 && xrsp == '0)
      else $error("answer without a request");
   a_ce_hold: assert property (!ce |=> $stable(ext_mode) && $stable(prio_out))
      else $error("state moved while clock enable low");
   a_dst_phys: assert property (ce && dst_valid && !dst_logical && is_compat
      && dst_id[7:0] == id_reg[7:0] |=> dst_hit_valid && dst_hit)
      else $error("compat physical destination missed");
   a_route_vec: assert property (ce && irq.valid && any_m
      |=> route_valid && route_vec == $past(irq.vec))
      else $error("routed vector lost");
endmodule

// File: common/liu_pkg.sv
// Function
// - compat mode serves the register set through a 4K-byte memory page.
// - extended mode serves the registers through model-specific register accesses.
// - memory-page accesses are dropped, unanswered, while extended mode is active.
// - physical id is 8 bits in compat mode, 32 bits in extended.
// - extended logical id splits into 16-bit cluster and 16-bit member fields.
// - fewer physical id bits may be stored; reads zero-extend them.
// - fewer cluster and member bits may be stored; reads zero-extend them.
// - extended registers answer only after switching into extended mode.
// - priority and delivery handling stay the same in both modes.
// - energy policy sends interrupts to active cores before waking deep idle ones.
// - performance policy prefers light idle cores over heavily loaded active ones.
package liu_pkg;
   localparam int unsigned PAGE_BYTES   = 4096;
   localparam int unsigned PAGE_AW      = 12;
   localparam int unsigned COMPAT_ID_W  = 8;
   localparam int unsigned EXT_ID_W     = 32;
   localparam int unsigned SUB_W        = 16;
   localparam int unsigned COMPAT_LSB   = 24;
   localparam logic [11:0] OFS_ID       = 12'h020;
   localparam logic [11:0] OFS_TPR      = 12'h080;
   localparam logic [11:0] OFS_LDR      = 12'h0D0;
   localparam logic [31:0] MSR_MODE     = 32'h0000001B;
   localparam logic [31:0] MSR_ID       = 32'h00000802;
   localparam logic [31:0] MSR_TPR      = 32'h00000808;
   localparam logic [31:0] MSR_LDR      = 32'h0000080D;
   localparam logic [31:0] MODE_EXT_MSK = 32'h00000400;
   localparam logic [7:0]  RST_TPR      = 8'h00;
   localparam logic [31:0] RST_ID       = 32'h00000000;
   localparam logic [15:0] RST_SUB      = 16'h0000;

   typedef enum logic {LIU_COMPAT, LIU_EXT} liu_mode_e;
   typedef enum logic {LIU_ENERGY, LIU_PERF} liu_policy_e;
   typedef enum logic [1:0] {LIU_ACTIVE, LIU_LIGHT, LIU_DEEP} liu_cstate_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } liu_mreq_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] index;
      logic [31:0] wdata;
   } liu_xreq_s;

   typedef struct packed {
      logic        ack;
      logic        drop;
      logic [31:0] rdata;
   } liu_rsp_s;

   typedef struct packed {
      logic        valid;
      liu_policy_e policy;
      logic [7:0]  vec;
   } liu_irq_s;
endpackage

// File: verif/liu_src_model.sv
`timescale 1ns/1ps
module liu_src_model
   import liu_pkg::*;
(
   // request from the bench
   input  wire logic                  go,
   input  wire logic                  pol,
   input  wire logic [7:0]            vec,
   input  wire logic [7:0]            st,
   input  wire logic [3:0]            bz,
   // toward the router
   output liu_pkg::liu_irq_s          irq,
   output liu_pkg::liu_cstate_e [3:0] core_state,
   output logic [3:0]                 core_busy
);
   typedef liu_cstate_e [3:0] liu_st4_t;
   // vector scrambled while no request stands
   assign irq        = '{valid: go, policy: liu_policy_e'(pol), vec: go ? vec : ~vec};
   assign core_state = liu_st4_t'(st);
   assign core_busy  = bz;
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import liu_pkg::*;
   logic                      clk = 1'b0;
   logic                      sys_rst = 1'b1;
   liu_mreq_s                 mreq = '0;
   liu_xreq_s                 xreq = '0;
   liu_rsp_s                  mrsp, xrsp, r;
   logic                      dst_valid = 1'b0;
   logic                      dst_logical = 1'b0;
   logic [31:0]               dst_id = '0;
   logic                      dst_hit_valid, dst_hit, ext_mode, route_valid;
   logic [31:0]               phys_id_out, log_id_out, seed = 32'h29, rid, ldr;
   logic [7:0]                prio_out, route_vec, pvec = '0, pst = '0;
   logic [1:0]                route_core;
   logic                      go = 1'b0, pol = 1'b0, ce = 1'b1;
   logic [3:0]                pbz = '0;
   liu_irq_s                  irq;
   liu_cstate_e [3:0]         core_state;
   logic [3:0]                core_busy;
   int                        num_errors = 0, checked = 0, cyc = 0;

   always #20 clk = ~clk;

   liu_top liu_top_inst (.clk, .sys_rst, .ce, .mreq, .mrsp, .xreq, .xrsp, .dst_valid,
      .dst_logical, .dst_id, .dst_hit_valid, .dst_hit, .ext_mode, .phys_id_out, .log_id_out,
      .prio_out, .irq, .core_state, .core_busy, .route_valid, .route_core, .route_vec);
   liu_src_model liu_src_model_inst (.go, .pol, .vec(pvec), .st(pst), .bz(pbz), .irq,
      .core_state, .core_busy);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // lowest index wins inside each class
   function automatic logic [1:0] exp_route(input logic p, input logic [7:0] s, input logic [3:0] b);
      int a, l, f, d;
      a = -1; l = -1; f = -1; d = -1;
      for (int i = 3; i >= 0; i--)
      begin
         case (s[2*i +: 2])
            2'h0: begin a = i; if (!b[i]) f = i; end
            2'h1: l = i;
            2'h2: d = i;
            default: ;
         endcase
      end
      if (!p) return 2'(a >= 0 ? a : (l >= 0 ? l : d));
      return 2'(l >= 0 ? l : (f >= 0 ? f : (a >= 0 ? a : d)));
   endfunction

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic end_sim();
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic acc(input bit pg, input bit wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk); #1;
      if (pg) mreq = '{1'b1, wr, a[11:0], wd};
      else xreq = '{1'b1, wr, a, wd};
      @(posedge clk); #1;
      mreq.valid = 1'b0;
      xreq.valid = 1'b0;
      r = pg ? mrsp : xrsp;
   endtask

   task automatic dst(input logic lg, input logic [31:0] id, input logic e);
      @(posedge clk); #1;
      dst_valid = 1'b1; dst_logical = lg; dst_id = id;
      @(posedge clk); #1;
      dst_valid = 1'b0;
      chk(dst_hit_valid, 1);
      chk(dst_hit, e);
   endtask

   task automatic rt(input logic p, input logic [7:0] s, input logic [3:0] b);
      logic [7:0] v;
      v = 8'(rnd());
      @(posedge clk); #1;
      go = 1'b1; pol = p; pvec = v; pst = s; pbz = b;
      @(posedge clk); #1;
      go = 1'b0;
      chk(route_valid, 1);
      chk(route_core, exp_route(p, s, b));
      chk(route_vec, v);
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         end_sim();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      chk(ext_mode, 0);
      chk(phys_id_out, 0);
      acc(1, 1, OFS_ID, 32'hA5000000); chk(r.ack, 1);
      acc(1, 0, OFS_ID, 0); chk(r.rdata, 32'hA5000000);
      chk(phys_id_out, 32'h000000A5);
      dst(0, 32'hFFFF00A5, 1);
      acc(1, 1, OFS_TPR, 32'h0000003C); chk(prio_out, 8'h3C);
      acc(1, 0, 32'h7F0, 0); chk({r.ack, r.drop}, 2'b01);
      acc(0, 0, MSR_ID, 0); chk({r.ack, r.drop}, 2'b01);
      acc(0, 1, MSR_MODE, MODE_EXT_MSK); chk(r.ack, 1);
      chk(ext_mode, 1);
      acc(1, 0, OFS_ID, 0); chk({r.ack, r.drop}, 2'b01);
      acc(1, 1, OFS_TPR, 32'hFF); chk({r.ack, r.drop}, 2'b01);
      chk(prio_out, 8'h3C);
      chk(phys_id_out, 32'h000000A5);
      repeat (8)
      begin
         rid = rnd();
         acc(0, 1, MSR_ID, rid);
         acc(0, 0, MSR_ID, 0); chk(r.rdata, rid);
         chk(phys_id_out, rid);
         dst(0, rid, 1);
         dst(0, rid ^ 32'h80000000, 0);
         ldr = rnd() | 32'h1;
         acc(0, 1, MSR_LDR, ldr); chk(log_id_out, ldr);
         dst(1, {ldr[31:16], 16'h0001}, 1);
         dst(1, {~ldr[31:16], 16'h0001}, 0);
         acc(0, 1, MSR_TPR, {24'h0, rid[7:0]}); chk(prio_out, rid[7:0]);
      end
      acc(0, 0, MSR_LDR, 0); chk(r.rdata, ldr);
      acc(0, 0, MSR_TPR, 0); chk(r.rdata, {24'h0, rid[7:0]});
      acc(0, 0, MSR_MODE, 0); chk(r.rdata, MODE_EXT_MSK);
      acc(0, 1, MSR_MODE, 0); chk(ext_mode, 0);
      chk(phys_id_out, {24'h0, rid[7:0]});
      acc(1, 0, OFS_TPR, 0); chk(r.rdata, {24'h0, rid[7:0]});
      acc(1, 1, OFS_LDR, 32'h5A000000); chk(log_id_out, 32'h5A);
      acc(1, 0, OFS_LDR, 0); chk(r.rdata, 32'h5A000000);
      dst(1, 32'h00000002, 1);
      dst(1, 32'h00000001, 0);
      acc(0, 1, MSR_MODE, MODE_EXT_MSK); chk(log_id_out, 32'h0000005A);
      chk(phys_id_out, rid);
      // clock enable low: request must not be taken
      @(posedge clk);
      #1 ce = 1'b0;
      acc(0, 1, MSR_TPR, {24'h0, ~rid[7:0]}); chk({r.ack, r.drop}, 2'b00);
      ce = 1'b1;
      chk(prio_out, rid[7:0]);
      rt(0, 8'b10_00_01_10, 4'h4);
      rt(0, 8'hAA, 4'h0);
      rt(1, 8'b01_00_00_10, 4'h6);
      rt(1, 8'b00_00_00_10, 4'h2);
      rt(1, 8'b10_00_00_10, 4'h6);
      repeat (40)
      begin
         for (int i = 0; i < 4; i++)
            pst[2*i +: 2] = 2'(rnd() % 3);
         rt(1'(rnd()), pst, 4'(rnd()));
      end
      // reset in mid-run returns to compat mode
      @(posedge clk);
      #1 sys_rst = 1'b1;
      @(posedge clk);
      #1 sys_rst = 1'b0;
      chk(ext_mode, 0);
      chk(prio_out, RST_TPR);
      acc(0, 0, MSR_ID, 0); chk({r.ack, r.drop}, 2'b01);
      end_sim();
   end
endmodule
